// ### logic/acje_exec.sv
`timescale 1ns/10ps
`include "acje_regs.svh"

module acje_exec (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire acje_pkg::acje_req_s req_i,
    input wire acje_pkg::acje_latch_t port_latch_i,
    output logic busy_o,
    output logic done_o,
    output logic illegal_o,
    output acje_pkg::acje_res_s res_o
);
    import acje_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode.

    wire logic [7:0] op = req_i.opcode;
    wire logic [3:0] op_hi = op[7:4];
    wire logic [3:0] op_lo = op[3:0];

    wire logic lo_reg = op_lo[3];
    wire logic lo_dir = op_lo == `ACJE_LO_DIR;
    wire logic lo_ind = op_lo[3:1] == `ACJE_LO_IND_HI;
    wire logic lo_imm = op_lo == `ACJE_LO_IMM;

    wire logic is_add_with_carry_op = (op_hi == `ACJE_HI_ADD_WITH_CARRY_OP) &&
        (lo_reg || lo_dir || lo_ind || lo_imm);
    wire logic is_add_imm = (op_hi == `ACJE_HI_ADD) &&
        lo_imm;
    wire logic is_absolute_jump_op =
        op[4:0] == `ACJE_ABSOLUTE_JUMP_OP_LO;
    wire logic is_anl_acc = (op_hi == `ACJE_HI_ANL) &&
        (lo_reg || lo_dir || lo_ind || lo_imm);
    wire logic is_anl_dir_a = (op_hi == `ACJE_HI_ANL) &&
        (op_lo == `ACJE_LO_DIR_A);
    wire logic is_anl_dir_imm = (op_hi == `ACJE_HI_ANL) &&
        (op_lo == `ACJE_LO_DIR_IMM);
    wire logic is_add = is_add_with_carry_op || is_add_imm;
    wire logic is_known = is_add || is_absolute_jump_op || is_anl_acc ||
        is_anl_dir_a || is_anl_dir_imm;
    wire logic two_cycle =
        is_absolute_jump_op || is_anl_dir_imm;

    ////////////////////////////////////////////////////////////////////////
    // Source operand selection.

    wire logic [7:0] src_byte = lo_reg ? req_i.reg_val :
        lo_dir ? req_i.dir_val :
        lo_ind ? req_i.ind_val :
        req_i.byte2;

    ////////////////////////////////////////////////////////////////////////
    // Port latch lookup for read-modify-write on a direct destination.

    logic [`ACJE_NUM_PORTS-1:0] port_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `ACJE_NUM_PORTS; gi++) begin : g_port
            assign port_hit[gi] =
                ((req_i.byte2 & `ACJE_PORT_MASK) == `ACJE_PORT_BASE) &&
                (req_i.byte2[`ACJE_PORT_IDX_MSB:`ACJE_PORT_IDX_LSB] ==
                 2'(gi));
        end
    endgenerate

    wire logic is_port = |port_hit;
    wire logic [1:0] port_idx =
        req_i.byte2[`ACJE_PORT_IDX_MSB:`ACJE_PORT_IDX_LSB];
    wire logic [7:0] dest_orig = is_port ? port_latch_i[port_idx] :
        req_i.dir_val;
    wire logic [7:0] dir_mask =
        is_anl_dir_imm ? req_i.byte3 : req_i.acc;

    ////////////////////////////////////////////////////////////////////////
    // Adder with flag generation.

    wire logic cin = is_add_with_carry_op ? req_i.cy : 1'b0;
    wire logic [8:0] sum9 = {1'b0, req_i.acc} + {1'b0, src_byte} +
        {8'h00, cin};
    wire logic [4:0] sum_lo4 = {1'b0, req_i.acc[3:0]} +
        {1'b0, src_byte[3:0]} + {4'h0, cin};
    wire logic [7:0] sum_lo7 = {1'b0, req_i.acc[6:0]} +
        {1'b0, src_byte[6:0]} + {7'h00, cin};
    wire logic carry7 = sum9[8];
    wire logic carry3 = sum_lo4[4];
    wire logic carry6 = sum_lo7[7];
    wire logic ovf = carry6 ^ carry7;

    ////////////////////////////////////////////////////////////////////////
    // Absolute jump target.

    wire logic [15:0] pc_after = req_i.pc + `ACJE_ABSOLUTE_JUMP_OP_LEN;
    wire logic [15:0] jump_target = {pc_after[15:11],
        op[`ACJE_ABSOLUTE_JUMP_OP_PAGE_MSB:`ACJE_ABSOLUTE_JUMP_OP_PAGE_LSB],
        req_i.byte2};

    ////////////////////////////////////////////////////////////////////////
    // Result assembly.

    acje_res_s next_res;

    always_comb begin
        next_res = '0;
        next_res.dir_addr = req_i.byte2;
        next_res.pc = jump_target;
        if (is_add) begin
            next_res.acc_we = 1'b1;
            next_res.acc = sum9[7:0];
            next_res.flags_we = 1'b1;
            next_res.cy = carry7;
            next_res.ac = carry3;
            next_res.ov = ovf;
        end else if (is_anl_acc) begin
            next_res.acc_we = 1'b1;
            next_res.acc = req_i.acc & src_byte;
        end else if (is_anl_dir_a || is_anl_dir_imm) begin
            next_res.dir_we = 1'b1;
            next_res.dir_data = dest_orig & dir_mask;
        end else if (is_absolute_jump_op) begin
            next_res.pc_we = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one-cycle forms answer at once, two-cycle forms wait one.

    acje_state_e state;
    acje_res_s pend;

    wire logic take = ce_i && req_valid_i && (state == ACJE_IDLE);
    wire logic take_long = take && is_known && two_cycle;
    wire logic take_short = take && !(is_known && two_cycle);
    wire logic finish_long =
        ce_i && (state == ACJE_SECOND);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= ACJE_IDLE;
        end else if (take_long) begin
            state <= ACJE_SECOND;
        end else if (finish_long) begin
            state <= ACJE_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend <= '0;
        end else if (take_long) begin
            pend <= next_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flags: each one is a flip-flop frozen while ce_i is low.

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
        end else if (ce_i) begin
            busy_o <= take_long;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= take_short || finish_long;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            illegal_o <= 1'b0;
        end else if (ce_i) begin
            illegal_o <= take_short && !is_known;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result register: data fields hold, write strobes clear on the next enabled cycle without a new result.

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            res_o <= '0;
            res_o.pc <= `ACJE_PC_RST;
            res_o.acc <= `ACJE_BYTE_RST;
        end else if (ce_i) begin
            if (finish_long) begin
                res_o <= pend;
            end else if (take_short && is_known) begin
                res_o <= next_res;
            end else begin
                res_o.acc_we <= 1'b0;
                res_o.flags_we <= 1'b0;
                res_o.dir_we <= 1'b0;
                res_o.pc_we <= 1'b0;
            end
        end
    end

endmodule

// ### logic/acje_pkg.sv
package acje_pkg;

    typedef logic [3:0][7:0] acje_latch_t;

    typedef enum logic [0:0] {
        ACJE_IDLE,
        ACJE_SECOND
    } acje_state_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [15:0] pc;
        logic [7:0] acc;
        logic cy;
        logic reg_sel_unused;
        logic [7:0] reg_val;
        logic [7:0] dir_val;
        logic [7:0] ind_val;
    } acje_req_s;

    typedef struct packed {
        logic acc_we;
        logic [7:0] acc;
        logic flags_we;
        logic cy;
        logic ac;
        logic ov;
        logic dir_we;
        logic [7:0] dir_addr;
        logic [7:0] dir_data;
        logic pc_we;
        logic [15:0] pc;
    } acje_res_s;

endpackage

// ### logic/acje_regs.svh
`ifndef ACJE_REGS_SVH
`define ACJE_REGS_SVH

// Upper opcode nibbles of the add and byte-AND groups.
`define ACJE_HI_ADD 4'h2
`define ACJE_HI_ADD_WITH_CARRY_OP 4'h3
`define ACJE_HI_ANL 4'h5

// Low opcode nibbles that select the source operand.
`define ACJE_LO_IMM 4'h4
`define ACJE_LO_DIR 4'h5
`define ACJE_LO_IND_HI 3'h3
`define ACJE_LO_DIR_A 4'h2
`define ACJE_LO_DIR_IMM 4'h3

// Absolute jump: low five opcode bits, page field position.
`define ACJE_ABSOLUTE_JUMP_OP_LO 5'h01
`define ACJE_ABSOLUTE_JUMP_OP_PAGE_MSB 7
`define ACJE_ABSOLUTE_JUMP_OP_PAGE_LSB 5

// Instruction length of the absolute jump, added before the page is taken.
`define ACJE_ABSOLUTE_JUMP_OP_LEN 16'h0002

// Output port latches sit at direct addresses 10dd0000 with d in 0..3.
`define ACJE_PORT_MASK 8'hCF
`define ACJE_PORT_BASE 8'h80
`define ACJE_PORT_IDX_MSB 5
`define ACJE_PORT_IDX_LSB 4
`define ACJE_NUM_PORTS 4

// Reset values.
`define ACJE_BYTE_RST 8'h00
`define ACJE_PC_RST 16'h0000

`endif

// ### verif/acje_exec_chk.sv
`timescale 1ns/10ps
`include "acje_regs.svh"
module acje_exec_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire acje_pkg::acje_req_s req_i,
    input wire acje_pkg::acje_latch_t port_latch_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire acje_pkg::acje_res_s res_o
);
    import acje_pkg::*;
    wire [7:0] op = req_i.opcode;
    wire [7:0] b2 = req_i.byte2;
    wire take = ce_i & req_valid_i & ~busy_o;
    wire [7:0] src = op[3] ? req_i.reg_val : (op[2:1] == 2'b11) ?
        req_i.ind_val : op[0] ? req_i.dir_val : b2;
    wire cin = (op[7:4] == 4'h3) & req_i.cy;
    wire [8:0] s9 = {1'b0, req_i.acc} + {1'b0, src} + {8'h00, cin};
    wire [4:0] s5 = {1'b0, req_i.acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    wire [7:0] s7 = {1'b0, req_i.acc[6:0]} + {1'b0, src[6:0]} + {7'h00, cin};
    wire [7:0] sum8 = s9[7:0];
    wire sum_cy = s9[8];
    wire sum_ac = s5[4];
    wire sum_ov = s9[8] ^ s7[7];
    wire add_t = take & ((op[7:4] == 4'h3 && op[3:0] >= 4'h4) || op == 8'h24);
    wire and_t = take & (op[7:4] == 4'h5) & (op[3:0] >= 4'h4);
    wire [7:0] and_v = req_i.acc & src;
    wire is_port = (b2 & `ACJE_PORT_MASK) == `ACJE_PORT_BASE;
    wire [7:0] dval = is_port ? port_latch_i[b2[5:4]] : req_i.dir_val;
    wire [7:0] anl_d = req_i.acc & dval;
    wire [7:0] anl_i = req_i.byte3 & dval;
    wire [15:0] pc2 = req_i.pc + `ACJE_ABSOLUTE_JUMP_OP_LEN;
    wire [15:0] jt = {pc2[15:11], op[7:5], b2};
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    add_sum_a: assert property (
        add_t |=> done_o && res_o.acc_we && res_o.acc == $past(sum8))
        else $error("add result wrong");
    carry_flags_a: assert property (
        add_t |=> res_o.flags_we &&
        res_o.cy == $past(sum_cy) && res_o.ac == $past(sum_ac))
        else $error("add carry flags wrong");
    ovf_flag_a: assert property (
        add_t |=> res_o.ov == $past(sum_ov))
        else $error("overflow flag wrong");
    and_acc_a: assert property (
        and_t |=> done_o && res_o.acc_we && res_o.acc == $past(and_v))
        else $error("and into acc wrong");
    and_flags_a: assert property (
        take && op[7:4] == 4'h5 |=> !res_o.flags_we)
        else $error("and touched flags");
    and_dir_a: assert property (
        take && op == 8'h52 |=> done_o &&
        res_o.dir_we && res_o.dir_addr == $past(b2) &&
        res_o.dir_data == $past(anl_d))
        else $error("and into direct wrong");
    and_imm_a: assert property (
        take && op == 8'h53 ##1 ce_i |->
        busy_o && !done_o ##1 done_o && res_o.dir_we &&
        res_o.dir_data == $past(anl_i, 2))
        else $error("and imm wrong");
    jump_dest_a: assert property (
        take && op[4:0] == 5'h01 ##1 ce_i |->
        busy_o ##1 done_o && res_o.pc_we && res_o.pc == $past(jt, 2))
        else $error("jump target wrong");
endmodule
bind acje_exec acje_exec_chk chk_u (.clk_i, .reset_i, .ce_i, .req_valid_i,
    .req_i, .port_latch_i, .busy_o, .done_o, .illegal_o, .res_o);

// ### verif/add_carry_jump_and_exec_tb.sv
`timescale 1ns/10ps
module add_carry_jump_and_exec_tb;
    import acje_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic ce_i = 1'b1;
    acje_req_s req_i = '0;
    acje_latch_t port_latch_i = {8'h0F, 8'hA5, 8'hFF, 8'h5A};
    logic busy_o, done_o, illegal_o;
    acje_res_s res_o;
    acje_req_s r;
    int error_cnt = 0;
    int compares = 0;
    acje_exec dut_u (.clk_i, .reset_i, .ce_i, .req_valid_i, .req_i,
        .port_latch_i, .busy_o, .done_o, .illegal_o, .res_o);
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] op);
        int n;
        n = 0;
        r.opcode = op;
        @(posedge clk_i);
        req_i <= r;
        req_valid_i <= 1'b1;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        while (done_o !== 1'b1 && n < 3) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(done_o, 1'b1);
    endtask
    task automatic s_add_with_carry_op();
        logic [7:0] ops [5] = '{8'h3F, 8'h35, 8'h36, 8'h34, 8'h24};
        logic [7:0] exp [5] = '{8'h90, 8'hA0, 8'hB0, 8'hC0, 8'hBF};
        r = '{8'h38, 8'h00, 8'h00, 16'h0, 8'hC3, 1'b1, 1'b0,
            8'hAA, 8'h0, 8'h0};
        run(8'h38);
        chk(res_o.acc, 8'h6E);
        chk({res_o.cy, res_o.ac, res_o.ov}, 3'b101);
        r = '{8'h00, 8'h40, 8'h00, 16'h0, 8'h7F, 1'b1, 1'b0,
            8'h10, 8'h20, 8'h30};
        for (int i = 0; i < 5; i++) begin
            run(ops[i]);
            chk(res_o.acc, exp[i]);
        end
    endtask
    task automatic s_absolute_jump_op();
        r = '{8'h00, 8'h23, 8'h00, 16'h0345, 8'h0, 1'b0, 1'b0,
            8'h0, 8'h0, 8'h0};
        run(8'h21);
        chk(res_o.pc, 16'h0123);
        r.byte2 = 8'hFF;
        r.pc = 16'h07FE;
        run(8'hE1);
        chk({res_o.pc_we, res_o.pc}, 17'h10FFF);
    endtask
    task automatic s_stall();
        r.cy = 1'b1;
        r.acc = 8'hC3;
        r.reg_val = 8'hAA;
        r.opcode = 8'h38;
        @(posedge clk_i);
        req_i <= r;
        req_valid_i <= 1'b1;
        ce_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(done_o, 1'b0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        chk({done_o, res_o.acc}, 9'h16E);
        run(8'h00);
        chk({illegal_o, res_o.acc_we, res_o.flags_we}, 3'b100);
    endtask
    task automatic s_anl();
        logic [7:0] ops [4] = '{8'h5A, 8'h55, 8'h57, 8'h54};
        logic [7:0] exp [4] = '{8'h01, 8'h82, 8'h03, 8'h40};
        r = '{8'h00, 8'h90, 8'h73, 16'h0, 8'hC3, 1'b0, 1'b0,
            8'h11, 8'h0, 8'h33};
        run(8'h53);
        chk({res_o.dir_addr, res_o.dir_data}, 16'h9073);
        r.byte2 = 8'h30;
        r.dir_val = 8'hAA;
        run(8'h52);
        chk(res_o.dir_data, 8'h82);
        r.byte2 = 8'hB0;
        run(8'h52);
        chk(res_o.dir_data, 8'h03);
        r.byte2 = 8'h44;
        for (int i = 0; i < 4; i++) begin
            run(ops[i]);
            chk({res_o.flags_we, res_o.acc},
                {1'b0, exp[i]});
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #5000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        s_add_with_carry_op();
        s_absolute_jump_op();
        s_anl();
        s_stall();
        print_verdict();
    end
endmodule
